/* hdl/bbif_pkg.sv */
// Functional notes
// - Flag register is 16 bits, read only, resets to 0x0080.
// - Bit 15 sets on special command done, clears after a read.
// - Bit 14 sets when the auxiliary converter sequence ends, clears on read.
// - Burst mode only: bits 13 and 12 flag end of message, clear on read.
// - Bits 11 to 8 flag FIFO overflow or underflow, clear on read.
// - Bit 7 follows the transmit level trigger and is never cleared by reading.
// - Bits 6 to 4 follow the tone and receive level triggers, never cleared by reading.
// - Bit 3 sets on transmit done, clears on read.
// - Burst mode only: bits 2 and 1 flag packet ready, clear on read.
// - Bit 0 sets when a counter nudge completes, clears on read.
// - Enable mask is 16 bits, write only, zero after reset.
// - Mask writes are taken any time and never touch the flags.
// - Host interrupt line is open drain, driven from the enabled flags.
package bbif_pkg;

    // =====================================================================
    // Register map
    localparam int          BBIF_ADDR_W       = 8;
    localparam int          BBIF_DATA_W       = 16;
    localparam logic [7:0]  BBIF_FLAGS_ADDR   = 8'h80;
    localparam logic [7:0]  BBIF_MASK_ADDR    = 8'h81;
    localparam logic [15:0] BBIF_FLAGS_RESET  = 16'h0080;
    localparam logic [15:0] BBIF_MASK_RESET   = 16'h0000;

    // =====================================================================
    // Field positions of the flag register
    localparam int BBIF_SPCL_DONE_BIT   = 15;
    localparam int BBIF_AUX_DONE_BIT    = 14;
    localparam int BBIF_RX2_ALERT_BIT   = 13;
    localparam int BBIF_RX1_ALERT_BIT   = 12;
    localparam int BBIF_TX_ERR_BIT      = 11;
    localparam int BBIF_TONE_ERR_BIT    = 10;
    localparam int BBIF_RX2_ERR_BIT     = 9;
    localparam int BBIF_RX1_ERR_BIT     = 8;
    localparam int BBIF_TX_TRIG_BIT     = 7;
    localparam int BBIF_TONE_TRIG_BIT   = 6;
    localparam int BBIF_RX2_TRIG_BIT    = 5;
    localparam int BBIF_RX1_TRIG_BIT    = 4;
    localparam int BBIF_TX_DONE_BIT     = 3;
    localparam int BBIF_RX2_BURST_BIT   = 2;
    localparam int BBIF_RX1_BURST_BIT   = 1;
    localparam int BBIF_NUDGE_DONE_BIT  = 0;

    // Bits that clear on read; the rest follow their level sources.
    localparam logic [15:0] BBIF_COR_MASK   = 16'hFF0F;
    // Bits that only burst mode may raise.
    localparam logic [15:0] BBIF_BURST_MASK = 16'h3006;

endpackage

/* hdl/bbif_flag_if.sv */
`timescale 1ns/100ps
`default_nettype none

// =========================================================================
// Flag bank carrier: set and clear requests in, flag state back out.
interface bbif_flag_if;
    import bbif_pkg::*;
    logic [BBIF_DATA_W-1:0] set_vec;
    logic [BBIF_DATA_W-1:0] clr_vec;
    logic [BBIF_DATA_W-1:0] level_vec;
    logic [BBIF_DATA_W-1:0] flags;

    modport bank (
        input  set_vec,
        input  clr_vec,
        input  level_vec,
        output flags
    );

    modport ctrl (
        output set_vec,
        output clr_vec,
        output level_vec,
        input  flags
    );
endinterface

`default_nettype wire

/* hdl/bbif_flag_bank.sv */
`timescale 1ns/100ps
`default_nettype none

// =========================================================================
// One flip-flop per flag: sticky bits for events, followers for levels.
module bbif_flag_bank
    import bbif_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst,
    bbif_flag_if.bank   fl
);

    logic [BBIF_DATA_W-1:0] flag_r;

    // =====================================================================
    // Per-bit storage.
    // A set in the same cycle as a read clear wins, so no event is lost.
    genvar gi;
    generate
        for (gi = 0; gi < BBIF_DATA_W; gi = gi + 1) begin : g_bit
            if (BBIF_COR_MASK[gi]) begin : g_sticky
                always_ff @(posedge clk) begin
                    if (rst) begin
                        flag_r[gi] <= BBIF_FLAGS_RESET[gi];
                    end else if (fl.set_vec[gi]) begin
                        flag_r[gi] <= 1'b1;
                    end else if (fl.clr_vec[gi]) begin
                        flag_r[gi] <= 1'b0;
                    end
                end
            end else begin : g_level
                // Level bits copy their source each cycle; a read has no effect.
                always_ff @(posedge clk) begin
                    if (rst) begin
                        flag_r[gi] <= BBIF_FLAGS_RESET[gi];
                    end else begin
                        flag_r[gi] <= fl.level_vec[gi];
                    end
                end
            end
        end
    endgenerate

    assign fl.flags = flag_r;

endmodule

`default_nettype wire

/* hdl/bbif_top.sv */
`timescale 1ns/100ps
`default_nettype none

// =========================================================================
// Interrupt flag collection with an enable mask and an open-drain line.
// Registers are reached through the device's register access port, which
// the serial control port decoder drives with one-cycle strobes.
module bbif_top
    import bbif_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Register access port.
    input  wire logic [BBIF_ADDR_W-1:0] reg_addr,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [BBIF_DATA_W-1:0] reg_wdata,
    output logic      [BBIF_DATA_W-1:0] reg_rdata,
    output logic                        reg_rvalid,
    // Mode.
    input  wire logic                   burst_mode,
    // Event pulses from the device's own logic.
    input  wire logic                   spcl_cmd_done,
    input  wire logic                   aux_adc_done,
    input  wire logic                   rx2_state_alert,
    input  wire logic                   rx1_state_alert,
    input  wire logic                   tx_fifo_error,
    input  wire logic                   tone_fifo_error,
    input  wire logic                   rx2_fifo_error,
    input  wire logic                   rx1_fifo_error,
    input  wire logic                   tx_done,
    input  wire logic                   rx2_burst_avail,
    input  wire logic                   rx1_burst_avail,
    input  wire logic                   nudge_done,
    // Level triggers, bit 7 of each channel's status word.
    input  wire logic                   tx_fifo_trigger,
    input  wire logic                   tone_fifo_trigger,
    input  wire logic                   rx2_fifo_trigger,
    input  wire logic                   rx1_fifo_trigger,
    // Open-drain host interrupt line.
    input  wire logic                   host_interrupt_line_i,
    output logic                        host_interrupt_line_o,
    output logic                        host_interrupt_line_oe
);

    // =====================================================================
    // Declarations
    bbif_flag_if fl ();

    logic [BBIF_DATA_W-1:0] mask_r;
    logic [BBIF_DATA_W-1:0] rdata_r;
    logic [BBIF_DATA_W-1:0] rdata_nxt;
    logic                   rvalid_r;
    logic [BBIF_DATA_W-1:0] ev_vec;
    logic [BBIF_DATA_W-1:0] set_vec;
    logic [BBIF_DATA_W-1:0] clr_vec;
    logic [BBIF_DATA_W-1:0] level_vec;
    logic [BBIF_DATA_W-1:0] pending;
    wire                    flag_sel;
    wire                    mask_sel;
    wire                    flag_rd;
    wire                    mask_wr;
    wire                    irq_active;

    // =====================================================================
    // Flag storage
    bbif_flag_bank u_bank (
        .clk (clk),
        .rst (rst),
        .fl  (fl.bank)
    );

    // =====================================================================
    // Address decode.
    // The mask is write only, so a read of it falls into the zero answer.
    assign flag_sel = (reg_addr == BBIF_FLAGS_ADDR);
    assign mask_sel = (reg_addr == BBIF_MASK_ADDR);
    assign flag_rd  = reg_rd && flag_sel;
    assign mask_wr  = reg_wr && mask_sel;

    // =====================================================================
    // Event gathering into flag positions.
    always_comb begin
        ev_vec                      = '0;
        ev_vec[BBIF_SPCL_DONE_BIT]  = spcl_cmd_done;
        ev_vec[BBIF_AUX_DONE_BIT]   = aux_adc_done;
        ev_vec[BBIF_RX2_ALERT_BIT]  = rx2_state_alert;
        ev_vec[BBIF_RX1_ALERT_BIT]  = rx1_state_alert;
        ev_vec[BBIF_TX_ERR_BIT]     = tx_fifo_error;
        ev_vec[BBIF_TONE_ERR_BIT]   = tone_fifo_error;
        ev_vec[BBIF_RX2_ERR_BIT]    = rx2_fifo_error;
        ev_vec[BBIF_RX1_ERR_BIT]    = rx1_fifo_error;
        ev_vec[BBIF_TX_DONE_BIT]    = tx_done;
        ev_vec[BBIF_RX2_BURST_BIT]  = rx2_burst_avail;
        ev_vec[BBIF_RX1_BURST_BIT]  = rx1_burst_avail;
        ev_vec[BBIF_NUDGE_DONE_BIT] = nudge_done;
    end

    // Level sources sit at their own positions; other bits stay zero.
    always_comb begin
        level_vec                     = '0;
        level_vec[BBIF_TX_TRIG_BIT]   = tx_fifo_trigger;
        level_vec[BBIF_TONE_TRIG_BIT] = tone_fifo_trigger;
        level_vec[BBIF_RX2_TRIG_BIT]  = rx2_fifo_trigger;
        level_vec[BBIF_RX1_TRIG_BIT]  = rx1_fifo_trigger;
    end

    // =====================================================================
    // Set and clear requests.
    // Burst-only events are dropped outside burst mode. A read clears only
    // the bits it actually returned as one, so an event that lands during
    // the read stays pending for the next read instead of vanishing.
    assign set_vec = ev_vec & BBIF_COR_MASK
                   & (burst_mode ? {BBIF_DATA_W{1'b1}} : ~BBIF_BURST_MASK);
    assign clr_vec = flag_rd ? (fl.flags & BBIF_COR_MASK) : '0;

    assign fl.set_vec   = set_vec;
    assign fl.clr_vec   = clr_vec;
    assign fl.level_vec = level_vec;

    // =====================================================================
    // Enable mask: any value is accepted at any time, flags untouched.
    always_ff @(posedge clk) begin
        if (rst) begin
            mask_r <= BBIF_MASK_RESET;
        end else if (mask_wr) begin
            mask_r <= reg_wdata;
        end
    end

    // =====================================================================
    // Read answer, one cycle after the strobe.
    // Unmapped addresses and the write-only mask read back as zero.
    assign rdata_nxt = flag_rd ? fl.flags : '0;

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r  <= '0;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r  <= reg_rd ? rdata_nxt : rdata_r;
            rvalid_r <= reg_rd;
        end
    end

    assign reg_rdata  = rdata_r;
    assign reg_rvalid = rvalid_r;

    // =====================================================================
    // Interrupt line.
    // The pin only ever drives low; the pull-up outside makes the high.
    // The line input is not needed here since nothing else shares it.
    assign pending                = fl.flags & mask_r;
    assign irq_active             = |pending;
    assign host_interrupt_line_o  = 1'b0;
    assign host_interrupt_line_oe = irq_active;

    // =====================================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_RESET_VALUE: assert property (@(posedge clk)
        $fell(rst) |-> (fl.flags == BBIF_FLAGS_RESET) && (mask_r == BBIF_MASK_RESET))
        else $error("flag or mask register wrong after reset");

    AST_EVENT_SETS: assert property (
        (set_vec != '0) |=> ((fl.flags & $past(set_vec)) == $past(set_vec)))
        else $error("event did not set its flag");

    AST_READ_CLEARS: assert property (
        (flag_rd && set_vec == '0)
        |=> ((fl.flags & $past(fl.flags) & BBIF_COR_MASK) == '0))
        else $error("read did not clear the clear-on-read flags");

    AST_SET_BEATS_CLEAR: assert property (
        (flag_rd && (set_vec & fl.flags) != '0)
        |=> ((fl.flags & $past(set_vec)) == $past(set_vec)))
        else $error("event lost during a read");

    AST_BURST_GATE: assert property (
        (!burst_mode && (fl.flags & BBIF_BURST_MASK) == '0)
        |=> ((fl.flags & BBIF_BURST_MASK) == '0))
        else $error("burst-only flag rose outside burst mode");

    AST_BURST_PASS: assert property (
        (burst_mode && rx1_burst_avail) |=> fl.flags[BBIF_RX1_BURST_BIT])
        else $error("burst flag not set in burst mode");

    AST_LEVEL_MIRROR: assert property (
        !$past(rst) |-> (fl.flags[7:4] == $past(level_vec[7:4])))
        else $error("level bits do not follow their sources");

    AST_LEVEL_READ: assert property (
        (flag_rd && level_vec[7:4] == fl.flags[7:4])
        |=> (fl.flags[7:4] == $past(fl.flags[7:4])))
        else $error("level bit disturbed by a read");

    AST_MASK_WRITE: assert property (
        mask_wr |=> (mask_r == $past(reg_wdata)))
        else $error("mask write not stored");

    AST_MASK_NO_FLAG: assert property (
        (mask_wr && !flag_rd && set_vec == '0)
        |=> ((fl.flags & BBIF_COR_MASK) == ($past(fl.flags) & BBIF_COR_MASK)))
        else $error("mask write changed the flags");

    AST_IRQ_OFF: assert property (
        (mask_wr && reg_wdata == '0) |=> !host_interrupt_line_oe [*2])
        else $error("line driven with all sources masked");

    AST_IRQ_ON: assert property (
        (fl.flags[BBIF_TX_TRIG_BIT] && mask_r[BBIF_TX_TRIG_BIT])
        |-> host_interrupt_line_oe && !host_interrupt_line_o)
        else $error("enabled flag does not pull the line low");

    AST_READ_DATA: assert property (
        flag_rd |=> reg_rvalid && (reg_rdata == $past(fl.flags)))
        else $error("flag read returned wrong data");

    COV_READ_CLEAR: cover property (flag_rd && fl.flags[BBIF_SPCL_DONE_BIT] ##1 reg_rvalid);
    COV_SET_ON_READ: cover property (flag_rd && (set_vec & fl.flags) != '0);
    COV_IRQ_RISE: cover property ($rose(host_interrupt_line_oe));
    COV_MASK_OFF: cover property (host_interrupt_line_oe ##1 mask_wr ##1 !host_interrupt_line_oe);

endmodule

`default_nettype wire

/* dv/bbif_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// Host controller: pull-up on the interrupt wire and interrupt-driven reads.
module bbif_host_model
    import bbif_pkg::*;
#(
    parameter int WAIT_LIMIT = 64
)
(
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   line_o,
    input  wire logic                   line_oe,
    input  wire logic                   service_en,
    input  wire logic                   rvalid,
    output logic                        line,
    output logic                        host_rd,
    output logic      [BBIF_ADDR_W-1:0] host_addr,
    output logic                        timed_out
);
    logic busy_r;
    int   wait_cnt_r;

    // The pull-up wins whenever nobody sinks the wire.
    assign line      = (line_oe && !line_o) ? 1'b0 : 1'b1;
    assign host_addr = BBIF_FLAGS_ADDR;

    // Reads only after the wire falls, never by polling, so a late event is not lost.
    // The wait for an interrupt is bounded so a dead line is noticed.
    always_ff @(posedge clk) begin
        if (rst) begin
            host_rd    <= 1'b0;
            busy_r     <= 1'b0;
            wait_cnt_r <= 0;
            timed_out  <= 1'b0;
        end else begin
            host_rd <= service_en && !line && !busy_r && !host_rd;
            if (host_rd) begin
                busy_r <= 1'b1;
            end else if (rvalid) begin
                busy_r <= 1'b0;
            end
            wait_cnt_r <= (service_en && line) ? wait_cnt_r + 1 : 0;
            if (wait_cnt_r == WAIT_LIMIT) begin
                timed_out <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

/* dv/test_baseband_interrupt_flags.sv */
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

// =====================================================================
// Self-checking bench: table of event patterns, then hand-written corner cases.
module test_baseband_interrupt_flags;
    import bbif_pkg::*;
    logic        clk, rst, b_rd, reg_wr, burst_mode, service_en;
    logic        reg_rvalid, line_o, line_oe, line, h_rd, timed_out;
    logic [7:0]  b_addr, h_addr;
    logic [15:0] reg_wdata, ev, reg_rdata, got;
    int          checks, mismatches, n;
    // Each row is burst mode, event vector, expected first read.
    localparam logic [32:0] ROWS [4] = '{
        {1'b1, 16'hFFFF, 16'hFFFF}, {1'b0, 16'hFFFF, 16'hCFF9},
        {1'b0, 16'h8001, 16'h8001}, {1'b1, 16'h0C50, 16'h0C50}};

    bbif_top bbif_top_inst (.clk(clk), .rst(rst),
        .reg_addr(h_rd ? h_addr : b_addr), .reg_wr(reg_wr), .reg_rd(b_rd | h_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .burst_mode(burst_mode), .spcl_cmd_done(ev[15]), .aux_adc_done(ev[14]),
        .rx2_state_alert(ev[13]), .rx1_state_alert(ev[12]), .tx_fifo_error(ev[11]),
        .tone_fifo_error(ev[10]), .rx2_fifo_error(ev[9]), .rx1_fifo_error(ev[8]),
        .tx_fifo_trigger(ev[7]), .tone_fifo_trigger(ev[6]), .rx2_fifo_trigger(ev[5]),
        .rx1_fifo_trigger(ev[4]), .tx_done(ev[3]), .rx2_burst_avail(ev[2]),
        .rx1_burst_avail(ev[1]), .nudge_done(ev[0]), .host_interrupt_line_i(line),
        .host_interrupt_line_o(line_o), .host_interrupt_line_oe(line_oe));

    bbif_host_model #(.WAIT_LIMIT(64)) bbif_host_model_inst (.clk(clk), .rst(rst),
        .line_o(line_o), .line_oe(line_oe), .service_en(service_en),
        .rvalid(reg_rvalid), .line(line), .host_rd(h_rd), .host_addr(h_addr),
        .timed_out(timed_out));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic results();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // The trailing edge keeps back-to-back calls from touching the strobe twice at once.
    task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
        b_addr = a;
        b_rd = 1'b1;
        @(posedge clk); #1;
        b_rd = 1'b0;
        n = 0;
        while (reg_rvalid !== 1'b1 && n < 8) begin
            @(posedge clk); #1;
            n++;
        end
        if (n == 8) begin
            mismatches++;
            results();
        end
        d = reg_rdata;
        @(posedge clk); #1;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        b_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk); #1;
        reg_wr = 1'b0;
        @(posedge clk); #1;
    endtask

    // Event bits pulse for one cycle; level bits stay up afterwards.
    task automatic pulse(input logic b, input logic [15:0] v);
        burst_mode = b;
        ev = v;
        @(posedge clk); #1;
        ev = v & 16'h00F0;
    endtask

    initial begin
        rst = 1'b1;
        b_rd = 1'b0;
        reg_wr = 1'b0;
        b_addr = 8'h00;
        reg_wdata = 16'h0000;
        ev = 16'h0000;
        burst_mode = 1'b0;
        service_en = 1'b0;
        checks = 0;
        mismatches = 0;
        repeat (5) @(posedge clk);
        #1;
        `CHK(line, 1'b1)
        rst = 1'b0;
        reg_read(BBIF_FLAGS_ADDR, got); `CHK(got, BBIF_FLAGS_RESET)
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            pulse(ROWS[i][32], ROWS[i][31:16]);
            reg_read(BBIF_FLAGS_ADDR, got); `CHK(got, ROWS[i][15:0])
            reg_read(BBIF_FLAGS_ADDR, got); `CHK(got, ROWS[i][15:0] & ~BBIF_COR_MASK)
            ev = 16'h0000;
            @(posedge clk); #1;
            $display("test row %0d done", i);
        end
        // Refused reads and writes.
        reg_read(BBIF_MASK_ADDR, got); `CHK(got, 16'h0000)
        reg_read(8'h42, got); `CHK(got, 16'h0000)
        reg_write(BBIF_FLAGS_ADDR, 16'hFFFF);
        reg_read(BBIF_FLAGS_ADDR, got); `CHK(got, 16'h0000)
        $display("test refusals done");
        // A held level trigger survives a read, and a zero mask releases the line.
        reg_write(BBIF_MASK_ADDR, 16'h0080);
        pulse(1'b0, 16'h0080);
        reg_read(BBIF_FLAGS_ADDR, got); `CHK(got, 16'h0080)
        `CHK(line, 1'b0)
        reg_write(BBIF_MASK_ADDR, 16'h0000);
        `CHK(line, 1'b1)
        ev = 16'h0000;
        @(posedge clk); #1;
        reg_read(BBIF_FLAGS_ADDR, got); `CHK(got, 16'h0000)
        $display("test level trigger done");
        // Mask gating and mask writes that leave flags alone.
        reg_write(BBIF_MASK_ADDR, 16'h0008);
        pulse(1'b0, 16'h0008);
        `CHK(line, 1'b0)
        reg_write(BBIF_MASK_ADDR, 16'h0001);
        `CHK(line, 1'b1)
        reg_read(BBIF_FLAGS_ADDR, got); `CHK(got, 16'h0008)
        $display("test mask done");
        // Event in the same cycle as a read of that same set flag survives the clear.
        pulse(1'b0, 16'h0001);
        @(posedge clk); #1;
        ev = 16'h0001;
        b_addr = BBIF_FLAGS_ADDR;
        b_rd = 1'b1;
        @(posedge clk); #1;
        ev = 16'h0000;
        b_rd = 1'b0;
        @(posedge clk); #1;
        `CHK(line, 1'b0)
        reg_read(BBIF_FLAGS_ADDR, got); `CHK(got, 16'h0001)
        `CHK(line, 1'b1)
        $display("test set beats clear done");
        // Host services the interrupt on its own.
        reg_write(BBIF_MASK_ADDR, 16'h8000);
        service_en = 1'b1;
        pulse(1'b0, 16'h8000);
        n = 0;
        while (line !== 1'b1 && n < 20) begin
            @(posedge clk); #1;
            n++;
        end
        `CHK(line, 1'b1)
        `CHK(timed_out, 1'b0)
        service_en = 1'b0;
        reg_read(BBIF_FLAGS_ADDR, got); `CHK(got, 16'h0000)
        $display("test host service done");
        results();
    end
endmodule

`default_nettype wire
